/* rtl/bit_shaper.sv */
`timescale 1ns/1ps
// pseudo open-drain bit driver for the debug pin: low phase, then a brief high push
module bit_shaper #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_bit,
  output logic o_busy,
  output logic o_drive_low,
  output logic o_drive_high
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] LOW_ONE = CW'(BIT_CYCLES / 4);
  localparam logic [CW-1:0] LOW_ZERO = CW'((BIT_CYCLES * 3) / 4);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] low_len_q;

  // one bit time of exactly BIT_CYCLES cycles
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
      low_len_q <= '0;
    end else if (i_start && cnt_q == '0) begin
      cnt_q <= CW'(BIT_CYCLES);
      low_len_q <= i_bit ? LOW_ONE : LOW_ZERO;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);
  // low for the first part of the bit, then a one-cycle speed-up push
  assign o_drive_low = o_busy && (CW'(BIT_CYCLES) - cnt_q) < low_len_q;
  assign o_drive_high = o_busy && (CW'(BIT_CYCLES) - cnt_q) == low_len_q;
endmodule

/* rtl/cycle_timer.sv */
`timescale 1ns/1ps
// loadable down counter; busy while non-zero
module cycle_timer #(
  parameter int WIDTH = 7
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy
);
  logic [WIDTH-1:0] cnt_q;

  // load wins over counting so a retrigger restarts the full length
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);
endmodule

/* rtl/reset_and_mode_select_pins.sv */
`timescale 1ns/1ps
`include "rst_mode_consts.svh"
// Notes on behaviour
// - after power-on reset the shared pin acts as external reset input
// - clearing the reset-pin enable frees the pin for gpio or comparator use
// - once gpio, the pin stays gpio until power-on or low-voltage reset
// - with reset enabled, an outside low on the pin resets the device
// - any non-power-on reset drives the enabled reset pin low 66 cycles
// - each reset's cause sets its matching bit in reset cause status
// - during power-on or debug-forced reset the debug pin selects mode
// - once reset ends the debug pin serves background debug traffic
// - debug pin high at reset release gives normal mode unless it is a power-on reset with boot select low
// - debug pin held low for 16 cycles after power-on or debug-forced release forces halt mode
// - each debug bit lasts 16 debug clock cycles, up to bus rate
// - debug pin is pseudo open-drain with brief active high pushes
// - boot select low at power-on with debug pin high selects bootloader
// - boot select pull-up on during power-on, then pin is output only
// - after reset the system runs from the internal generated clock
// - interrupt pin feeds the request; when disabled it is freed
// - both select pins low at power-on selects background mode
// - internal resets and both pins high select normal run mode
module reset_and_mode_select_pins
  import rst_mode_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic i_lvd,
  input wire logic i_internal_reset_req,
  input wire logic i_debug_forced_reset_bit,
  input wire logic i_reset_pin_function_enable,
  input wire logic i_gpio_select,
  input wire logic i_shared_reset_pin_in,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  input wire logic i_debug_mode_select_pin_in,
  input wire logic i_boot_loader_select_pin_in,
  input wire logic i_boot_gpio_out,
  input wire logic i_irq_pin_in,
  input wire logic i_irq_enable,
  input wire logic i_dbg_tx_start,
  input wire logic i_dbg_tx_bit,
  input wire logic i_ext_clk_select,
  output logic o_shared_reset_pin_out,
  output logic o_shared_reset_pin_oe,
  output logic o_comparator_in,
  output logic o_gpio_in,
  output rst_mode_pkg::pin_func_type o_pin_func,
  output logic o_system_reset,
  output logic [`CAUSE_W-1:0] o_reset_cause_status,
  output rst_mode_pkg::run_mode_type o_run_mode,
  output logic o_mode_valid,
  output logic o_debug_pin_out,
  output logic o_debug_pin_oe,
  output logic o_debug_rx,
  output logic o_dbg_tx_busy,
  output logic o_boot_pin_pullup,
  output logic o_boot_pin_out,
  output logic o_boot_pin_oe,
  output logic o_irq_request,
  output logic o_irq_pin_free,
  output logic o_use_internal_clk
);
  import rst_mode_pkg::*;

  localparam logic [6:0] DRIVE_LEN = 7'(`RST_DRIVE_CYCLES);
  localparam logic [4:0] HOLD_LEN = 5'(`MODE_HOLD_CYCLES);

  logic gpio_lock_q;
  logic pin_rst_en;
  logic ext_rst;
  logic any_reset;
  logic non_por_reset;
  logic rst_active_q;
  logic drive_busy;
  logic drive_load;
  logic [`CAUSE_W-1:0] cause_q;
  logic mode_reset_q;
  logic por_seen_q;
  logic [4:0] hold_q;
  logic ms_low_q;
  logic bl_low_q;
  run_mode_type mode_q;
  logic mode_valid_q;
  logic dbg_low;
  logic dbg_high;
  logic in_rst_q;

  // pin stays reset until software frees it; a gpio choice sticks past
  // ordinary resets, cleared only by power-on or low voltage
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_por || i_lvd) begin
      gpio_lock_q <= 1'b0;
    end else if (!i_reset_pin_function_enable && i_gpio_select) begin
      gpio_lock_q <= 1'b1;
    end
  end

  // enabled after power-on since the enable input then reads its reset value
  assign pin_rst_en = !gpio_lock_q && i_reset_pin_function_enable;

  // function reported for the pin mux
  always_comb begin
    if (pin_rst_en) begin
      o_pin_func = pin_reset;
    end else if (gpio_lock_q || i_gpio_select) begin
      o_pin_func = pin_gpio;
    end else begin
      o_pin_func = pin_compare;
    end
  end

  // the pin's own low is ignored while we drive it, else it would retrigger
  assign ext_rst = pin_rst_en && !i_shared_reset_pin_in && !drive_busy;
  assign non_por_reset = !i_por && (i_lvd || i_internal_reset_req || ext_rst
                         || i_debug_forced_reset_bit);
  assign any_reset = i_por || non_por_reset;

  // start the drive on the first cycle of a non-power-on reset
  assign drive_load = non_por_reset && !rst_active_q && !drive_busy;

  cycle_timer #(
    .WIDTH(7)
  ) u_drive_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset || i_por),
    .i_load(drive_load),
    .i_count(DRIVE_LEN),
    .o_busy(drive_busy)
  );

  // track reset in progress to edge-detect the start of each reset
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rst_active_q <= 1'b1;
    end else begin
      rst_active_q <= any_reset || drive_busy;
    end
  end

  // pin drive: low during the reset stretch, gpio in gpio mode, released otherwise
  always_comb begin
    if (pin_rst_en) begin
      o_shared_reset_pin_out = 1'b0;
      o_shared_reset_pin_oe = drive_busy;
    end else if (o_pin_func == pin_gpio) begin
      o_shared_reset_pin_out = i_gpio_out;
      o_shared_reset_pin_oe = i_gpio_oe;
    end else begin
      o_shared_reset_pin_out = 1'b0;
      o_shared_reset_pin_oe = 1'b0;
    end
  end
  assign o_comparator_in = (o_pin_func == pin_compare) && i_shared_reset_pin_in;
  assign o_gpio_in = (o_pin_func == pin_gpio) && i_shared_reset_pin_in;
  assign o_system_reset = any_reset || drive_busy;

  // cause capture: one-hot per new reset; power-on overrides everything
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cause_q <= '0;
      cause_q[`CAUSE_POR] <= 1'b1;
    end else if (i_por) begin
      cause_q <= '0;
      cause_q[`CAUSE_POR] <= 1'b1;
    end else if (drive_load) begin
      cause_q <= '0;
      if (i_lvd) begin
        cause_q[`CAUSE_LVD] <= 1'b1;
      end else if (i_debug_forced_reset_bit) begin
        cause_q[`CAUSE_DBG] <= 1'b1;
      end else if (ext_rst) begin
        cause_q[`CAUSE_PIN] <= 1'b1;
      end else begin
        cause_q[`CAUSE_INT] <= 1'b1;
      end
    end
  end
  assign o_reset_cause_status = cause_q;

  // remember whether this reset may pick a mode (power-on or debug forced)
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mode_reset_q <= 1'b1;
      por_seen_q <= 1'b1;
    end else if (i_por) begin
      mode_reset_q <= 1'b1;
      por_seen_q <= 1'b1;
    end else if (i_debug_forced_reset_bit) begin
      mode_reset_q <= 1'b1;
      por_seen_q <= 1'b0;
    end else if (non_por_reset) begin
      mode_reset_q <= 1'b0;
      por_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    in_rst_q <= i_reset ? 1'b1 : o_system_reset;
  end

  // boot select is sampled only while power-on reset holds
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bl_low_q <= 1'b0;
    end else if (i_por) begin
      bl_low_q <= !i_boot_loader_select_pin_in;
    end
  end

  // hold window: count cycles after a mode-selecting release, tracking whether the debug pin stays low
  always_ff @(posedge i_core_clk) begin
    if (i_reset || o_system_reset) begin
      hold_q <= '0;
      ms_low_q <= 1'b0;
    end else if (in_rst_q && mode_reset_q) begin
      hold_q <= HOLD_LEN - 5'h01;
      ms_low_q <= !i_debug_mode_select_pin_in;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 5'h01;
      ms_low_q <= ms_low_q && !i_debug_mode_select_pin_in;
    end
  end

  // mode decision; valid at release, or after the hold window if a mode-selecting reset ends with the debug pin low
  always_ff @(posedge i_core_clk) begin
    if (i_reset || o_system_reset) begin
      mode_valid_q <= 1'b0;
      if (!mode_reset_q || i_internal_reset_req) begin
        mode_q <= mode_normal;
      end
    end else if (in_rst_q && !mode_reset_q) begin
      mode_q <= mode_normal;
      mode_valid_q <= 1'b1;
    end else if (in_rst_q && mode_reset_q && !i_debug_mode_select_pin_in) begin
      mode_valid_q <= 1'b0;
    end else if (in_rst_q && mode_reset_q) begin
      // pin high at release decides at once
      mode_q <= (por_seen_q && bl_low_q) ? mode_boot : mode_normal;
      mode_valid_q <= 1'b1;
    end else if (!mode_valid_q && hold_q == 5'h01) begin
      // held low through the window: halt wins over the bootloader
      mode_q <= (ms_low_q && !i_debug_mode_select_pin_in) ? mode_halt
                : ((por_seen_q && bl_low_q) ? mode_boot : mode_normal);
      mode_valid_q <= 1'b1;
    end
  end
  assign o_run_mode = mode_q;
  assign o_mode_valid = mode_valid_q;

  // background debug bit driver, idle during reset so mode select is undisturbed
  bit_shaper #(
    .BIT_CYCLES(`DBG_BIT_CYCLES)
  ) u_bit_shaper (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset || o_system_reset),
    .i_start(i_dbg_tx_start && mode_valid_q),
    .i_bit(i_dbg_tx_bit),
    .o_busy(o_dbg_tx_busy),
    .o_drive_low(dbg_low),
    .o_drive_high(dbg_high)
  );

  // pseudo open-drain: drive low, or a brief high push, else released
  assign o_debug_pin_out = dbg_high;
  assign o_debug_pin_oe = dbg_low || dbg_high;
  assign o_debug_rx = mode_valid_q && i_debug_mode_select_pin_in;

  // boot select pin: pulled up input during power-on, output only after
  assign o_boot_pin_pullup = i_por || (in_rst_q && por_seen_q && o_system_reset);
  assign o_boot_pin_oe = !o_system_reset;
  assign o_boot_pin_out = !o_system_reset && i_boot_gpio_out;

  // external interrupt pin; low-true request when enabled
  assign o_irq_request = i_irq_enable && !i_irq_pin_in;
  assign o_irq_pin_free = !i_irq_enable;

  // clock source stays internal from reset until software selects otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_reset || o_system_reset) begin
      o_use_internal_clk <= 1'b1;
    end else if (i_ext_clk_select) begin
      o_use_internal_clk <= 1'b0;
    end
  end

  a_drive_length: assert property (@(posedge i_core_clk) disable iff (i_reset || i_por)
    drive_load |=> drive_busy [*8]) else $error("reset pin drive ended early");
  a_gpio_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (gpio_lock_q && !i_por && !i_lvd) |=> !pin_rst_en) else $error("gpio lock lost");
  a_pin_low_oe: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_shared_reset_pin_oe && pin_rst_en |-> !o_shared_reset_pin_out)
    else $error("reset pin driven high");
  a_ext_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (pin_rst_en && !i_shared_reset_pin_in && !drive_busy) |-> o_system_reset)
    else $error("pin low did not reset");
  a_por_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_por |=> cause_q[`CAUSE_POR]) else $error("power-on cause missing");
  a_halt_mode: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode_valid_q && mode_q == mode_halt) |-> mode_reset_q)
    else $error("halt after plain reset");
  a_internal_normal: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(mode_valid_q) && !mode_reset_q |-> mode_q == mode_normal)
    else $error("internal reset not normal");
  a_dbg_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_system_reset |=> !o_debug_pin_oe) else $error("debug pin driven in reset");
  a_boot_pullup: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_por |-> o_boot_pin_pullup && !o_boot_pin_oe) else $error("boot pull-up off");

  // the status register must name exactly one cause, never zero or several
  a_cause_onehot: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $onehot(cause_q))
    else $error("reset cause not one-hot");
  // outside reset the boot select pin is an output with its pull-up off
  a_boot_output: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !o_system_reset |-> o_boot_pin_oe && !o_boot_pin_pullup)
    else $error("boot pin not output after reset");
  // every reset hands the system back to the internal clock
  a_internal_clk: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_system_reset |=> o_use_internal_clk)
    else $error("clock not internal after reset");
  // a request can only come from an enabled pin, which then is not free
  a_irq_owned: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_irq_request |-> !o_irq_pin_free)
    else $error("interrupt pin both free and requesting");
  // a debug bit runs its full length unless a reset cuts it
  a_bit_length: assert property (@(posedge i_core_clk) disable iff (i_reset || o_system_reset)
    $rose(o_dbg_tx_busy) |-> ##15 o_dbg_tx_busy ##1 !o_dbg_tx_busy)
    else $error("debug bit length wrong");
  // debug traffic only once the mode pin has been read and released
  a_tx_after_mode: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_dbg_tx_busy |-> mode_valid_q)
    else $error("debug traffic before mode decided");
  // a decided mode stays put until the next reset
  a_mode_stable: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode_valid_q && !o_system_reset) |=> $stable(mode_q))
    else $error("mode changed outside reset");
endmodule

/* rtl/rst_mode_consts.svh */
`ifndef RST_MODE_CONSTS_SVH
`define RST_MODE_CONSTS_SVH
// bus clock period in ps
`define CORE_CLK_PERIOD_PS 4000
// non-power-on reset drive length on the shared pin, in bus cycles
`define RST_DRIVE_CYCLES 66
// mode pin hold window after power-on or debug-forced reset release, in cycles
`define MODE_HOLD_CYCLES 16
// background debug bit time in debug clock cycles
`define DBG_BIT_CYCLES 16
// reset cause bit positions
`define CAUSE_POR 0
`define CAUSE_LVD 1
`define CAUSE_PIN 2
`define CAUSE_DBG 3
`define CAUSE_INT 4
`define CAUSE_W 5
// speed-up pulse length in cycles
`define SPEEDUP_CYCLES 1
`endif

/* rtl/rst_mode_pkg.sv */
package rst_mode_pkg;
  typedef enum logic [1:0] {
    mode_normal,
    mode_halt,
    mode_boot
  } run_mode_type;
  typedef enum logic [1:0] {
    pin_reset,
    pin_gpio,
    pin_compare
  } pin_func_type;
endpackage

/* tb/reset_host_model.sv */
`timescale 1ns/1ps
// far side: reset source, debug host and boot strap on pulled-up lines
module reset_host_model (
  input wire logic i_pull_reset_low,
  input wire logic i_hold_debug_low,
  input wire logic i_strap_boot_low,
  input wire logic i_reset_oe,
  input wire logic i_reset_out,
  input wire logic i_debug_oe,
  input wire logic i_debug_out,
  input wire logic i_boot_oe,
  input wire logic i_boot_out,
  output logic o_reset_level,
  output logic o_debug_level,
  output logic o_boot_level
);
  // wired lines: a low from either party wins, a released line floats high
  assign o_reset_level = !i_pull_reset_low && (!i_reset_oe || i_reset_out);
  // host holds the mode pin low through the window when halt is wanted
  assign o_debug_level = !i_hold_debug_low && (!i_debug_oe || i_debug_out);
  // strap resistor sets the level only while the device is not driving
  assign o_boot_level = i_boot_oe ? i_boot_out : !i_strap_boot_low;
endmodule

/* tb/test_reset_and_mode_select_pins.sv */
`timescale 1ns/1ps
`include "rst_mode_consts.svh"
module test_reset_and_mode_select_pins;
  import rst_mode_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset, i_por, i_lvd, i_internal_reset_req, i_debug_forced_reset_bit;
  logic i_reset_pin_function_enable, i_gpio_select, i_gpio_out, i_gpio_oe;
  logic i_boot_gpio_out, i_irq_pin_in, i_irq_enable, i_dbg_tx_start, i_dbg_tx_bit;
  logic i_ext_clk_select, pull_low, hold_low, strap_low;
  logic i_shared_reset_pin_in, i_debug_mode_select_pin_in, i_boot_loader_select_pin_in;
  logic o_shared_reset_pin_out, o_shared_reset_pin_oe, o_comparator_in, o_gpio_in;
  logic o_system_reset, o_mode_valid, o_debug_pin_out, o_debug_pin_oe, o_debug_rx;
  logic o_dbg_tx_busy, o_boot_pin_pullup, o_boot_pin_out, o_boot_pin_oe;
  logic o_irq_request, o_irq_pin_free, o_use_internal_clk;
  logic [`CAUSE_W-1:0] o_reset_cause_status;
  pin_func_type o_pin_func;
  run_mode_type o_run_mode;
  int bad_count = 0;
  int total_checks = 0;

  reset_and_mode_select_pins dut (
    .i_core_clk, .i_reset, .i_por, .i_lvd, .i_internal_reset_req, .i_debug_forced_reset_bit,
    .i_reset_pin_function_enable, .i_gpio_select, .i_shared_reset_pin_in, .i_gpio_out,
    .i_gpio_oe, .i_debug_mode_select_pin_in, .i_boot_loader_select_pin_in, .i_boot_gpio_out,
    .i_irq_pin_in, .i_irq_enable, .i_dbg_tx_start, .i_dbg_tx_bit, .i_ext_clk_select,
    .o_shared_reset_pin_out, .o_shared_reset_pin_oe, .o_comparator_in, .o_gpio_in,
    .o_pin_func, .o_system_reset, .o_reset_cause_status, .o_run_mode, .o_mode_valid,
    .o_debug_pin_out, .o_debug_pin_oe, .o_debug_rx, .o_dbg_tx_busy, .o_boot_pin_pullup,
    .o_boot_pin_out, .o_boot_pin_oe, .o_irq_request, .o_irq_pin_free, .o_use_internal_clk
  );

  reset_host_model host (
    .i_pull_reset_low(pull_low), .i_hold_debug_low(hold_low), .i_strap_boot_low(strap_low),
    .i_reset_oe(o_shared_reset_pin_oe), .i_reset_out(o_shared_reset_pin_out),
    .i_debug_oe(o_debug_pin_oe), .i_debug_out(o_debug_pin_out),
    .i_boot_oe(o_boot_pin_oe), .i_boot_out(o_boot_pin_out),
    .o_reset_level(i_shared_reset_pin_in), .o_debug_level(i_debug_mode_select_pin_in),
    .o_boot_level(i_boot_loader_select_pin_in)
  );

  // 250 MHz bus clock
  always #2 i_core_clk = ~i_core_clk;

  // mode expected from the kind of reset and the strap levels seen
  function automatic run_mode_type model_mode(bit mode_reset, bit dbg_low, bit boot_low);
    if (mode_reset && dbg_low) return mode_halt;
    if (mode_reset && boot_low) return mode_boot;
    return mode_normal;
  endfunction

  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %b seen %b", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic chk_mode(run_mode_type exp, run_mode_type got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD run_mode expected %0d seen %0d", exp, got);
      bad_count++;
    end
  endtask

  task automatic chk_count(string name, int exp, int got);
    total_checks++;
    if (got != exp) begin
      $display("BAD %s expected %0d seen %0d", name, exp, got);
      bad_count++;
    end
  endtask

  // bounded wait for reset release and a decided mode
  task automatic wait_valid();
    int n;
    n = 0;
    while (!(o_system_reset === 1'b0 && o_mode_valid === 1'b1)) begin
      @(negedge i_core_clk);
      n++;
      if (n > 400) begin
        $display("BAD mode_valid expected 1 seen %b", o_mode_valid);
        bad_count++;
        finish_test();
      end
    end
  endtask

  task automatic power_on(bit dbg_low, bit boot_low);
    @(negedge i_core_clk);
    hold_low = dbg_low;
    strap_low = boot_low;
    i_por = 1'b1;
    repeat (5) @(negedge i_core_clk);
    chk_bit("boot_pullup", 1'b1, o_boot_pin_pullup);
    i_por = 1'b0;
    // strap held past the 16-cycle window after release
    repeat (20) @(negedge i_core_clk);
    hold_low = 1'b0;
    strap_low = 1'b0;
    wait_valid();
    chk_mode(model_mode(1'b1, dbg_low, boot_low), o_run_mode);
    chk_bit("por_cause", 1'b1, o_reset_cause_status[`CAUSE_POR]);
    chk_bit("reset_func", 1'b1, o_pin_func === pin_reset);
    chk_bit("boot_pullup", 1'b0, o_boot_pin_pullup);
    chk_bit("boot_oe", 1'b1, o_boot_pin_oe);
    chk_bit("boot_out", i_boot_gpio_out, o_boot_pin_out);
  endtask

  // one-cycle non-power-on source; exp_drive below zero skips the drive count
  task automatic other_reset(int src, bit dbg_low, int exp_drive);
    int drive;
    bit seen;
    drive = 0;
    seen = 0;
    @(negedge i_core_clk);
    hold_low = dbg_low;
    i_ext_clk_select = 1'b1;
    @(negedge i_core_clk);
    i_ext_clk_select = 1'b0;
    i_internal_reset_req = (src == `CAUSE_INT);
    i_debug_forced_reset_bit = (src == `CAUSE_DBG);
    i_lvd = (src == `CAUSE_LVD);
    pull_low = (src == `CAUSE_PIN);
    @(negedge i_core_clk);
    {i_internal_reset_req, i_debug_forced_reset_bit, i_lvd, pull_low} = 4'h0;
    repeat (100) begin
      seen |= (o_system_reset === 1'b1);
      drive += (o_shared_reset_pin_oe === 1'b1 && o_shared_reset_pin_out === 1'b0);
      @(negedge i_core_clk);
    end
    if (exp_drive >= 0) chk_count("drive_cycles", exp_drive, drive);
    chk_bit("system_reset", 1'b1, seen);
    chk_bit("cause", 1'b1, o_reset_cause_status[src]);
    hold_low = 1'b0;
    wait_valid();
    chk_mode(model_mode(src == `CAUSE_DBG, dbg_low, 1'b0), o_run_mode);
    chk_bit("internal_clk", 1'b1, o_use_internal_clk);
  endtask

  task automatic send_debug_bit(logic b);
    int low_n, high_n, busy_n;
    low_n = 0;
    high_n = 0;
    busy_n = 0;
    @(negedge i_core_clk);
    i_dbg_tx_start = 1'b1;
    i_dbg_tx_bit = b;
    @(negedge i_core_clk);
    i_dbg_tx_start = 1'b0;
    repeat (24) begin
      busy_n += (o_dbg_tx_busy === 1'b1);
      low_n += (o_debug_pin_oe === 1'b1 && i_debug_mode_select_pin_in === 1'b0);
      high_n += (o_debug_pin_oe === 1'b1 && o_debug_pin_out === 1'b1);
      @(negedge i_core_clk);
    end
    chk_count("bit_time", `DBG_BIT_CYCLES, busy_n);
    chk_count("low_time", b ? 4 : 12, low_n);
    chk_count("speedup", `SPEEDUP_CYCLES, high_n);
  endtask

  // main sequence; inputs change on the falling edge only
  initial begin
    void'($urandom(45673));
    {i_reset, i_por, i_reset_pin_function_enable} = 3'h7;
    {i_lvd, i_internal_reset_req, i_debug_forced_reset_bit, i_gpio_select} = 4'h0;
    {i_gpio_out, i_gpio_oe, i_boot_gpio_out, i_irq_pin_in, i_irq_enable} = 5'h00;
    {i_dbg_tx_start, i_dbg_tx_bit, i_ext_clk_select, pull_low, hold_low, strap_low} = 6'h00;
    repeat (5) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset = 1'b0;
    i_por = 1'b0;
    wait_valid();
    for (int i = 0; i < 4; i++) begin
      i_boot_gpio_out = $urandom_range(1);
      power_on(i[0], i[1]);
    end
    other_reset(`CAUSE_INT, 1'b1, 66);
    other_reset(`CAUSE_DBG, 1'b1, 66);
    other_reset(`CAUSE_DBG, 1'b0, 66);
    other_reset(`CAUSE_PIN, 1'b0, 66);
    chk_bit("debug_rx", 1'b1, o_debug_rx);
    hold_low = 1'b1;
    repeat (3) @(negedge i_core_clk);
    chk_bit("debug_rx", 1'b0, o_debug_rx);
    chk_mode(mode_normal, o_run_mode);
    hold_low = 1'b0;
    for (int i = 0; i < 4; i++) send_debug_bit($urandom_range(1));
    send_debug_bit(1'b0);
    send_debug_bit(1'b1);
    repeat (8) begin
      @(negedge i_core_clk);
      {i_irq_enable, i_irq_pin_in} = 2'($urandom_range(3));
      @(negedge i_core_clk);
      chk_bit("irq_request", i_irq_enable && !i_irq_pin_in, o_irq_request);
      chk_bit("irq_free", !i_irq_enable, o_irq_pin_free);
    end
    // comparator first, then gpio, which must survive ordinary resets
    i_reset_pin_function_enable = 1'b0;
    pull_low = $urandom_range(1);
    @(negedge i_core_clk);
    chk_bit("compare_func", 1'b1, o_pin_func === pin_compare);
    chk_bit("compare_in", i_shared_reset_pin_in, o_comparator_in);
    i_gpio_select = 1'b1;
    @(negedge i_core_clk);
    chk_bit("gpio_in", i_shared_reset_pin_in, o_gpio_in);
    pull_low = 1'b0;
    i_gpio_select = 1'b0;
    i_reset_pin_function_enable = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk_bit("gpio_func", 1'b1, o_pin_func === pin_gpio);
    i_gpio_oe = 1'b1;
    i_gpio_out = $urandom_range(1);
    @(negedge i_core_clk);
    chk_bit("gpio_oe", 1'b1, o_shared_reset_pin_oe);
    chk_bit("gpio_out", i_gpio_out, o_shared_reset_pin_out);
    i_gpio_oe = 1'b0;
    other_reset(`CAUSE_INT, 1'b0, 0);
    chk_bit("gpio_kept", 1'b1, o_pin_func === pin_gpio);
    other_reset(`CAUSE_LVD, 1'b0, -1);
    chk_bit("reset_back", 1'b1, o_pin_func === pin_reset);
    finish_test();
  end
endmodule
